/* rtl/cwas_top.sv */
// Card write cycle generator with auxiliary chip select and interrupt routing.
// Assumes host and module inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Host controls form internal read/write strobes
// - Handshake pin is wait or acknowledge
// - Target picks primary, secondary or aux enable
// - Attribute select idle for common/aux access
// - Memory strobe for memory, else IO strobe
// - Module wait freezes strobe length counter
// - Memory strobe length per speed setting, IO strobe length fixed
// - Strobe delay after enable per setting
// - Hold then release enables, assert ack
// - Data buffers enabled before write strobe
// - Enable waits detection and previous completion
// - Wait raised as soon as write detected
// - Ack dropped when host ends write
// - Same timing for attribute and common
// - Aux select open-drain/push-pull, either polarity
// - Fallback selects aux when no module
// - Otherwise aux selected by address match
// - Manual code 11 selects aux
// - Aux select transmit or regenerate mode
// - Transmit mode follows host select
// - Regenerate mode acts like card enable
// - Aux interrupt routed with polarity, mask
// - Aux interrupt state readable
module cwas_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cwas_pkg::cwas_cpu_t cpuType,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic hostRwN,
  input wire logic hostDsN,
  input wire logic [15:0] hostAddr,
  input wire cwas_pkg::cwas_slot_cfg_t slotACfg,
  input wire cwas_pkg::cwas_slot_cfg_t slotBCfg,
  input wire logic [15:0] auxMask,
  input wire logic [15:0] auxPattern,
  input wire logic fallbackSelectEnable,
  input wire logic automaticTargetEnable,
  input wire logic [1:0] manualTarget,
  input wire logic auxCsMode,
  input wire cwas_pkg::cwas_pin_cfg_t auxCsCfg,
  input wire cwas_pkg::cwas_pin_cfg_t handshakeCfg,
  input wire logic modAWaitN,
  input wire logic modBWaitN,
  input wire logic auxIrqIn,
  input wire logic auxIrqPolarity,
  input wire logic auxIrqMask,
  output cwas_pkg::cwas_card_t cardOut,
  output cwas_pkg::cwas_pin_t handshakePin,
  output cwas_pkg::cwas_pin_t auxChipSelectOut,
  output logic dataBufOeN,
  output logic auxIrqStatus,
  output logic hostIrq
);
  import cwas_pkg::*;

  // ----------------------------------------
  // Types and functions
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_DETECT, ST_GAP, ST_SETUP, ST_STROBE, ST_HOLD, ST_ACK
  } cwas_state_t;

  typedef struct packed {
    cwas_state_t st;
    logic [3:0] cnt;
    logic [3:0] gap;
    cwas_tgt_t tgt;
    cwas_kind_t kind;
    cwas_speed_t speed;
    logic ceOn;
    logic strobeOn;
    logic waitAct;
    logic ackAct;
    logic bufOeN;
    cwas_card_t card;
    cwas_pin_t hs;
    cwas_pin_t auxCs;
  } cwas_top_state_t;

  function automatic logic addrHit(input logic [15:0] a, input logic [15:0] m,
                                   input logic [15:0] p);
    addrHit = ((a ^ p) & m) == 16'h0000;
  endfunction : addrHit

  function automatic logic longTiming(input cwas_kind_t k, input cwas_speed_t s);
    longTiming = (k == KIND_IO) || (k == KIND_SIDE) || (s == SPD600);
  endfunction : longTiming

  function automatic logic [3:0] strobeLen(input cwas_kind_t k, input cwas_speed_t s);
    if (k == KIND_IO || k == KIND_SIDE) begin
      strobeLen = STRB_IO;
    end else begin
      case (s)
        SPD600: strobeLen = STRB_600;
        SPD250: strobeLen = STRB_250;
        SPD200: strobeLen = STRB_200;
        SPD150: strobeLen = STRB_150;
        SPD100: strobeLen = STRB_100;
        default: strobeLen = STRB_600;
      endcase
    end
  endfunction : strobeLen

  function automatic cwas_pin_t pinDrive(input logic act, input cwas_pin_cfg_t c);
    logic lvl;
    cwas_pin_t p;
    lvl = act ~^ c.activeHigh;
    p.out = lvl;
    p.oe = c.openDrain ? ~lvl : 1'b1;
    pinDrive = p;
  endfunction : pinDrive

  // ----------------------------------------
  // Host strobes and interrupt routing
  // ----------------------------------------
  logic hostWr;
  logic hostCs;

  cwas_host_strobe u_host (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .cpuType(cpuType),
    .hostCsN(hostCsN),
    .hostRdN(hostRdN),
    .hostWrN(hostWrN),
    .hostRwN(hostRwN),
    .hostDsN(hostDsN),
    .hostRd(),
    .hostWr(hostWr),
    .hostCs(hostCs)
  );

  cwas_aux_irq u_irq (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .auxIrqIn(auxIrqIn),
    .auxIrqPolarity(auxIrqPolarity),
    .auxIrqMask(auxIrqMask),
    .auxIrqStatus(auxIrqStatus),
    .hostIrq(hostIrq)
  );

  // ----------------------------------------
  // Target decode
  // ----------------------------------------
  logic hitA;
  logic hitB;
  logic auxSel;
  cwas_tgt_t tgtNow;

  always_comb begin
    hitA = addrHit(hostAddr, slotACfg.mask, slotACfg.pattern);
    hitB = addrHit(hostAddr, slotBCfg.mask, slotBCfg.pattern);
    if (!automaticTargetEnable) begin
      case (manualTarget)
        MAN_A: tgtNow = TGT_A;
        MAN_B: tgtNow = TGT_B;
        MAN_AUX: tgtNow = TGT_AUX;
        default: tgtNow = TGT_NONE;
      endcase
    end else if (hitA) begin
      tgtNow = TGT_A;
    end else if (hitB) begin
      tgtNow = TGT_B;
    end else if (fallbackSelectEnable) begin
      tgtNow = hostCs ? TGT_AUX : TGT_NONE;
    end else begin
      tgtNow = addrHit(hostAddr, auxMask, auxPattern) ? TGT_AUX : TGT_NONE;
    end
    auxSel = hostCs && (tgtNow == TGT_AUX);
  end

  // ----------------------------------------
  // Write cycle state machine
  // ----------------------------------------
  cwas_top_state_t st_r;
  cwas_top_state_t st_nxt;
  logic modWaitAct;
  logic wrStart;

  assign modWaitAct = (st_r.tgt == TGT_A && !modAWaitN) || (st_r.tgt == TGT_B && !modBWaitN);
  assign wrStart = hostWr && (tgtNow == TGT_A || tgtNow == TGT_B ||
                              (tgtNow == TGT_AUX && auxCsMode));

  always_comb begin
    st_nxt = st_r;
    if (st_r.gap != CNT_ZERO) begin
      st_nxt.gap = st_r.gap - CNT_ONE;
    end
    case (st_r.st)
      ST_IDLE: begin
        if (wrStart) begin
          st_nxt.st = ST_DETECT;
          st_nxt.waitAct = 1'b1;
          st_nxt.tgt = tgtNow;
          st_nxt.kind = (tgtNow == TGT_B) ? slotBCfg.kind : slotACfg.kind;
          st_nxt.speed = (tgtNow == TGT_B) ? slotBCfg.speed : slotACfg.speed;
          if (tgtNow == TGT_AUX) begin
            st_nxt.kind = KIND_IO;
          end
        end
      end
      ST_DETECT: begin
        st_nxt.st = ST_GAP;
      end
      ST_GAP: begin
        if (st_r.gap == CNT_ZERO) begin
          st_nxt.st = ST_SETUP;
          st_nxt.ceOn = 1'b1;
          st_nxt.bufOeN = 1'b0;
          st_nxt.cnt = (longTiming(st_r.kind, st_r.speed) ? SETUP_LONG : SETUP_SHORT)
                       - CNT_ONE;
        end
      end
      ST_SETUP: begin
        if (st_r.cnt == CNT_ZERO) begin
          st_nxt.st = ST_STROBE;
          st_nxt.strobeOn = 1'b1;
          st_nxt.cnt = strobeLen(st_r.kind, st_r.speed) - CNT_ONE;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      ST_STROBE: begin
        if (modWaitAct) begin
          st_nxt.cnt = st_r.cnt;
        end else if (st_r.cnt == CNT_ZERO) begin
          st_nxt.st = ST_HOLD;
          st_nxt.strobeOn = 1'b0;
          st_nxt.cnt = ((st_r.speed == SPD600 && st_r.kind != KIND_IO && st_r.kind != KIND_SIDE)
                        ? HOLD_LONG : HOLD_SHORT) - CNT_ONE;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (st_r.cnt == CNT_ZERO) begin
          st_nxt.st = ST_ACK;
          st_nxt.ceOn = 1'b0;
          st_nxt.waitAct = 1'b0;
          st_nxt.ackAct = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      ST_ACK: begin
        if (!hostWr) begin
          st_nxt.st = ST_IDLE;
          st_nxt.ackAct = 1'b0;
          st_nxt.bufOeN = 1'b1;
          st_nxt.gap = GAP_CYC;
        end
      end
      default: begin
        st_nxt.st = ST_IDLE;
      end
    endcase
    // Pin formation
    st_nxt.card = CARD_IDLE;
    if (st_nxt.ceOn) begin
      st_nxt.card.priAN = !(st_nxt.tgt == TGT_A && st_nxt.kind != KIND_SIDE);
      st_nxt.card.priBN = !(st_nxt.tgt == TGT_B && st_nxt.kind != KIND_SIDE);
      st_nxt.card.secAN = !(st_nxt.tgt == TGT_A && st_nxt.kind == KIND_SIDE);
      st_nxt.card.secBN = !(st_nxt.tgt == TGT_B && st_nxt.kind == KIND_SIDE);
      st_nxt.card.attrN = !(st_nxt.tgt != TGT_AUX && st_nxt.kind == KIND_ATTR);
    end
    if (st_nxt.strobeOn) begin
      if (st_nxt.kind == KIND_ATTR || st_nxt.kind == KIND_COMMON) begin
        st_nxt.card.memWrN = 1'b0;
      end else begin
        st_nxt.card.ioWrN = 1'b0;
      end
    end
    st_nxt.hs = pinDrive(handshakeCfg.ackMode ? st_nxt.ackAct : st_nxt.waitAct,
                         handshakeCfg);
    if (auxCsMode) begin
      st_nxt.auxCs = pinDrive(st_nxt.ceOn && st_nxt.tgt == TGT_AUX, auxCsCfg);
    end else begin
      st_nxt.auxCs = pinDrive(auxSel, auxCsCfg);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{ST_IDLE, 4'h0, 4'h0, TGT_NONE, KIND_ATTR, SPD600, 1'b0, 1'b0, 1'b0,
                1'b0, 1'b1, CARD_IDLE, '{1'b1, 1'b1}, '{1'b1, 1'b1}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cardOut = st_r.card;
  assign handshakePin = st_r.hs;
  assign auxChipSelectOut = st_r.auxCs;
  assign dataBufOeN = st_r.bufOeN;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r.st == ST_IDLE |-> cardOut == CARD_IDLE)
    else $error("Card pins active while idle");

  a_wait_on_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.st == ST_IDLE && wrStart) |=> st_r.waitAct)
    else $error("Wait not raised at write start");

  a_attr_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.kind == KIND_COMMON || st_r.tgt == TGT_AUX) |-> cardOut.attrN)
    else $error("Attribute select during common or aux access");

  a_io_strobe_kind: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !cardOut.ioWrN |-> st_r.kind == KIND_IO || st_r.kind == KIND_SIDE)
    else $error("IO strobe on memory access");

  a_wait_freeze: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.st == ST_STROBE && modWaitAct) |=> st_r.cnt == $past(st_r.cnt) && st_r.strobeOn)
    else $error("Counter moved during module wait");

  a_buf_before: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(st_r.strobeOn) |-> !$past(st_r.bufOeN, 1) && !st_r.bufOeN)
    else $error("Buffers not enabled before strobe");

  a_strobe_fast: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ($rose(st_r.strobeOn) && st_r.kind == KIND_COMMON && st_r.speed == SPD100 && !modWaitAct)
    |=> st_r.strobeOn ##1 !st_r.strobeOn)
    else $error("Fast strobe length wrong");

  a_ack_after_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(st_r.ackAct) |-> !st_r.ceOn && !st_r.waitAct && !st_r.strobeOn)
    else $error("Ack raised with enable still active");

  a_ack_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.ackAct && !hostWr) |=> !st_r.ackAct)
    else $error("Ack held after host ended write");

endmodule : cwas_top
`default_nettype wire

/* rtl/cwas_pkg.sv */
// Package for the card write and auxiliary select block.
// Assumes a single device clock; all counts are in device clock cycles.
package cwas_pkg;

  typedef enum logic [2:0] {SPD600, SPD250, SPD200, SPD150, SPD100} cwas_speed_t;
  typedef enum logic [1:0] {KIND_ATTR, KIND_COMMON, KIND_IO, KIND_SIDE} cwas_kind_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_A, TGT_B, TGT_AUX} cwas_tgt_t;
  typedef enum logic {CPU_SPLIT, CPU_RWDS} cwas_cpu_t;

  // Manual target codes
  localparam logic [1:0] MAN_A = 2'h0;
  localparam logic [1:0] MAN_B = 2'h1;
  localparam logic [1:0] MAN_AUX = 2'h3;

  // Write strobe active length, cycles
  localparam logic [3:0] STRB_600 = 4'h9;
  localparam logic [3:0] STRB_250 = 4'h5;
  localparam logic [3:0] STRB_200 = 4'h4;
  localparam logic [3:0] STRB_150 = 4'h3;
  localparam logic [3:0] STRB_100 = 4'h2;
  localparam logic [3:0] STRB_IO = 4'h5;
  // Enable to strobe delay, cycles
  localparam logic [3:0] SETUP_LONG = 4'h2;
  localparam logic [3:0] SETUP_SHORT = 4'h1;
  // Strobe release to enable release, cycles
  localparam logic [3:0] HOLD_LONG = 4'h2;
  localparam logic [3:0] HOLD_SHORT = 4'h1;
  // Previous cycle completion gap, cycles
  localparam logic [3:0] GAP_CYC = 4'h2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] pattern;
    cwas_kind_t kind;
    cwas_speed_t speed;
  } cwas_slot_cfg_t;

  typedef struct packed {
    logic ackMode;
    logic activeHigh;
    logic openDrain;
  } cwas_pin_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } cwas_pin_t;

  typedef struct packed {
    logic priAN;
    logic priBN;
    logic secAN;
    logic secBN;
    logic attrN;
    logic memWrN;
    logic ioWrN;
  } cwas_card_t;

  localparam cwas_card_t CARD_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : cwas_pkg

/* rtl/cwas_host_strobe.sv */
// Combines host control inputs into host read, write and select levels.
// Assumes host inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cwas_host_strobe (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cwas_pkg::cwas_cpu_t cpuType,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic hostRwN,
  input wire logic hostDsN,
  output logic hostRd,
  output logic hostWr,
  output logic hostCs
);
  import cwas_pkg::*;

  typedef struct packed {
    logic rd;
    logic wr;
    logic cs;
  } cwas_hs_state_t;

  cwas_hs_state_t st_r;
  cwas_hs_state_t st_nxt;

  always_comb begin
    st_nxt.cs = ~hostCsN;
    if (cpuType == CPU_RWDS) begin
      st_nxt.rd = ~hostCsN & ~hostDsN & hostRwN;
      st_nxt.wr = ~hostCsN & ~hostDsN & ~hostRwN;
    end else begin
      st_nxt.rd = ~hostCsN & ~hostRdN;
      st_nxt.wr = ~hostCsN & ~hostWrN;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hostRd = st_r.rd;
  assign hostWr = st_r.wr;
  assign hostCs = st_r.cs;

endmodule : cwas_host_strobe
`default_nettype wire

/* rtl/cwas_aux_irq.sv */
// Auxiliary interrupt polarity, masking and status.
// Assumes the interrupt input is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cwas_aux_irq (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic auxIrqIn,
  input wire logic auxIrqPolarity,
  input wire logic auxIrqMask,
  output logic auxIrqStatus,
  output logic hostIrq
);
  import cwas_pkg::*;

  typedef struct packed {
    logic status;
    logic irq;
  } cwas_irq_state_t;

  cwas_irq_state_t st_r;
  cwas_irq_state_t st_nxt;

  always_comb begin
    st_nxt.status = ~(auxIrqIn ^ auxIrqPolarity);
    st_nxt.irq = st_nxt.status & ~auxIrqMask;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign auxIrqStatus = st_r.status;
  assign hostIrq = st_r.irq;

  a_irq_mask_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hostIrq |-> auxIrqStatus && !$past(auxIrqMask))
    else $error("Masked aux interrupt reached host");

endmodule : cwas_aux_irq
`default_nettype wire

/* verif/cwas_card_model.sv */
// Far-side card module model: drives the module wait lines.
// Assumes card outputs are active low and change on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cwas_card_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cwas_pkg::cwas_card_t cardOut,
  input wire logic [3:0] stallLen,
  output logic modAWaitN,
  output logic modBWaitN
);
  import cwas_pkg::*;
  // ----------------------------------------
  // Wait insertion at strobe start
  // ----------------------------------------
  int left;
  logic seen;
  logic strobe;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      left = 0;
      seen = 1'b0;
      modAWaitN <= 1'b1;
      modBWaitN <= 1'b1;
    end else begin
      strobe = !cardOut.memWrN || !cardOut.ioWrN;
      if (strobe && !seen) begin
        left = stallLen;
      end
      seen = strobe;
      modAWaitN <= !(left > 0 && (!cardOut.priAN || !cardOut.secAN));
      modBWaitN <= !(left > 0 && (!cardOut.priBN || !cardOut.secBN));
      if (left > 0) begin
        left = left - 1;
      end
    end
  end
endmodule : cwas_card_model
`default_nettype wire

/* verif/tb_top.sv */
// Testbench for the card write and auxiliary select block.
// Assumes the card model on the module side; the bench plays the host.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cwas_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  cwas_cpu_t cpuType = CPU_SPLIT;
  logic hostCsN = 1'b1, hostRdN = 1'b1, hostWrN = 1'b1, hostRwN = 1'b1, hostDsN = 1'b1;
  logic [15:0] hostAddr = 16'h0, auxMask = 16'h0, auxPattern = 16'h0;
  cwas_slot_cfg_t slotACfg = '0, slotBCfg = '0;
  logic fallbackSelectEnable = 1'b0, automaticTargetEnable = 1'b1, auxCsMode = 1'b0;
  logic [1:0] manualTarget = 2'h2;
  cwas_pin_cfg_t auxCsCfg = '0, handshakeCfg = '0;
  logic auxIrqIn = 1'b0, auxIrqPolarity = 1'b1, auxIrqMask = 1'b0;
  logic modAWaitN, modBWaitN, dataBufOeN, auxIrqStatus, hostIrq;
  logic [3:0] stallLen = 4'h0;
  cwas_card_t cardOut;
  cwas_pin_t handshakePin, auxChipSelectOut;
  int n_errors = 0, tests_run = 0, cycles = 0, seed = 45;

  always #10 ref_clk = ~ref_clk;

  cwas_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cpuType(cpuType), .hostCsN(hostCsN),
    .hostRdN(hostRdN), .hostWrN(hostWrN), .hostRwN(hostRwN), .hostDsN(hostDsN),
    .hostAddr(hostAddr), .slotACfg(slotACfg), .slotBCfg(slotBCfg), .auxMask(auxMask),
    .auxPattern(auxPattern), .fallbackSelectEnable(fallbackSelectEnable),
    .automaticTargetEnable(automaticTargetEnable), .manualTarget(manualTarget),
    .auxCsMode(auxCsMode), .auxCsCfg(auxCsCfg), .handshakeCfg(handshakeCfg),
    .modAWaitN(modAWaitN), .modBWaitN(modBWaitN), .auxIrqIn(auxIrqIn),
    .auxIrqPolarity(auxIrqPolarity), .auxIrqMask(auxIrqMask), .cardOut(cardOut),
    .handshakePin(handshakePin), .auxChipSelectOut(auxChipSelectOut),
    .dataBufOeN(dataBufOeN), .auxIrqStatus(auxIrqStatus), .hostIrq(hostIrq));

  cwas_card_model u_card (.ref_clk(ref_clk), .arst_n(arst_n), .cardOut(cardOut),
    .stallLen(stallLen), .modAWaitN(modAWaitN), .modBWaitN(modBWaitN));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic results();
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic check_int(input string name, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      n_errors++;
      $display("BAD %s exp %0d got %0d", name, exp, got);
    end
  endtask : check_int

  task automatic check_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask : check_bit

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  // ----------------------------------------
  // Reference timing
  // ----------------------------------------
  function automatic int expLen(cwas_kind_t k, cwas_speed_t s);
    if (k == KIND_IO || k == KIND_SIDE) return 5;
    case (s)
      SPD600: return 9;
      SPD250: return 5;
      SPD200: return 4;
      SPD150: return 3;
      default: return 2;
    endcase
  endfunction : expLen

  function automatic int expSetHold(cwas_kind_t k, cwas_speed_t s, bit hold);
    bit io;
    io = (k == KIND_IO || k == KIND_SIDE);
    if (!io && s == SPD600) return 2;
    if (io && !hold) return 2;
    return 1;
  endfunction : expSetHold

  // ----------------------------------------
  // Host write cycle, sel 0 slot A, 1 slot B, 2 aux regenerate
  // ----------------------------------------
  task automatic write_cycle(input int sel, input cwas_kind_t k, input cwas_speed_t s,
                             input int stall);
    int ceOn = -1, wrOn = -1, wrOff = -1, ceOff = -1, bufOn = -1, hsOn = -1, other = 0;
    logic ce, wr, ow, hs, hsEnd, attrSeen;
    logic [15:0] a;
    attrSeen = 1'b0;
    hsEnd = 1'b0;
    a = 16'($random(seed));
    @(posedge ref_clk);
    hostAddr <= a;
    slotACfg <= '{16'hffff, (sel == 0) ? a : ~a, k, s};
    slotBCfg <= '{16'hffff, a, k, s};
    automaticTargetEnable <= (sel != 2);
    manualTarget <= MAN_AUX;
    auxCsMode <= (sel == 2);
    stallLen <= 4'(stall);
    handshakeCfg <= '{s[0], s[2], s[1]};
    @(posedge ref_clk);
    hostCsN <= 1'b0;
    if (cpuType == CPU_RWDS) begin
      hostRwN <= 1'b0;
      hostDsN <= 1'b0;
    end else begin
      hostWrN <= 1'b0;
    end
    for (int t = 0; t < 80 && ceOff < 0; t++) begin
      @(negedge ref_clk);
      ce = (sel == 2) ? auxChipSelectOut.out : (sel == 0) ?
           (k == KIND_SIDE ? cardOut.secAN : cardOut.priAN) :
           (k == KIND_SIDE ? cardOut.secBN : cardOut.priBN);
      wr = (k == KIND_ATTR || k == KIND_COMMON) ? cardOut.memWrN : cardOut.ioWrN;
      ow = (k == KIND_ATTR || k == KIND_COMMON) ? cardOut.ioWrN : cardOut.memWrN;
      hs = (handshakePin.out === handshakeCfg.activeHigh);
      other += int'(!ow) + int'(!cardOut.priAN) + int'(!cardOut.priBN)
             + int'(!cardOut.secAN) + int'(!cardOut.secBN) - int'(sel != 2 && !ce);
      attrSeen |= !cardOut.attrN;
      if (hs && hsOn < 0) hsOn = t;
      if (!dataBufOeN && bufOn < 0) bufOn = t;
      if (!ce && ceOn < 0) ceOn = t;
      if (!wr && wrOn < 0) wrOn = t;
      if (wr && wrOn >= 0 && wrOff < 0) wrOff = t;
      if (ce && ceOn >= 0 && ceOff < 0) begin
        ceOff = t;
        hsEnd = hs;
      end
    end
    check_bit("ce delay", 1'b1, ceOn >= 3 && ceOn <= 7);
    check_int("strobe setup", expSetHold(k, s, 0), wrOn - ceOn);
    check_int("strobe length", expLen(k, s) + stall, wrOff - wrOn);
    check_int("enable hold", expSetHold(k, s, 1), ceOff - wrOff);
    check_bit("buffer lead", 1'b1, wrOn - bufOn >= expSetHold(k, s, 0));
    check_bit("attr select", k == KIND_ATTR, attrSeen);
    check_int("foreign outputs", 0, other);
    check_bit("handshake end", handshakeCfg.ackMode, hsEnd);
    check_bit("early wait", !handshakeCfg.ackMode, hsOn >= 0 && hsOn < ceOn);
    @(posedge ref_clk);
    hostCsN <= 1'b1;
    hostWrN <= 1'b1;
    hostRwN <= 1'b1;
    hostDsN <= 1'b1;
    repeat (5) @(negedge ref_clk);
    check_bit("handshake idle", 1'b0, handshakePin.out === handshakeCfg.activeHigh);
    check_bit("handshake idle oe", !handshakeCfg.openDrain || handshakeCfg.activeHigh,
              handshakePin.oe);
    check_bit("card idle", 1'b1, cardOut === CARD_IDLE && dataBufOeN === 1'b1);
  endtask : write_cycle

  // ----------------------------------------
  // Aux select in transmit mode
  // ----------------------------------------
  task automatic aux_sel(input logic autoEn, input logic fb, input logic [1:0] man,
                         input logic hit, input logic exp, input int cfg);
    logic [15:0] a;
    logic ah, od;
    a = 16'($random(seed));
    ah = cfg[1];
    od = cfg[0];
    @(posedge ref_clk);
    hostAddr <= a;
    slotACfg.pattern <= ~a;
    slotBCfg.pattern <= ~a;
    auxMask <= 16'hffff;
    auxPattern <= hit ? a : ~a;
    automaticTargetEnable <= autoEn;
    fallbackSelectEnable <= fb;
    manualTarget <= man;
    auxCsMode <= 1'b0;
    auxCsCfg <= '{1'b0, ah, od};
    @(posedge ref_clk);
    hostCsN <= 1'b0;
    hostRdN <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check_bit("aux cs level", exp ? ah : !ah, auxChipSelectOut.out);
    check_bit("aux cs enable", !od || !(exp ? ah : !ah), auxChipSelectOut.oe);
    @(posedge ref_clk);
    hostCsN <= 1'b1;
    hostRdN <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check_bit("aux cs off", !ah, auxChipSelectOut.out);
    check_bit("aux cs off enable", !od || ah, auxChipSelectOut.oe);
  endtask : aux_sel

  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      write_cycle(i % 2, (i % 2) ? KIND_ATTR : KIND_COMMON, cwas_speed_t'(i), 0);
    end
    write_cycle(0, KIND_IO, SPD250, 0);
    write_cycle(1, KIND_SIDE, SPD100, 0);
    write_cycle(2, KIND_IO, SPD200, 0);
    write_cycle(0, KIND_COMMON, SPD200, 3);
    cpuType <= CPU_RWDS;
    write_cycle(1, KIND_COMMON, SPD150, 0);
    cpuType <= CPU_SPLIT;
    for (int i = 0; i < 4; i++) begin
      aux_sel(1'b0, 1'b0, MAN_AUX, 1'b0, 1'b1, i);
      aux_sel(1'b1, 1'b1, MAN_A, 1'b0, 1'b1, i);
      aux_sel(1'b1, 1'b0, MAN_A, 1'b1, 1'b1, i);
      aux_sel(1'b1, 1'b0, MAN_A, 1'b0, 1'b0, i);
    end
    aux_sel(1'b0, 1'b0, MAN_A, 1'b1, 1'b0, 0);
    aux_sel(1'b0, 1'b0, MAN_B, 1'b1, 1'b0, 3);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {auxIrqIn, auxIrqPolarity, auxIrqMask} <= 3'(i);
      repeat (3) @(negedge ref_clk);
      check_bit("irq status", i[2] == i[1], auxIrqStatus);
      check_bit("host irq", i[2] == i[1] && !i[0], hostIrq);
    end
    results();
  end
endmodule : tb_top
`default_nettype wire
